// ===== rtl/mmc_pkg.sv
package mmc_pkg;

    // ************************************************************
    // register offsets
    // ************************************************************
    localparam logic [11:0] OFF_MODE_CTRL     = 12'h100;
    localparam logic [11:0] OFF_STN_ADDR_HI   = 12'h104;
    localparam logic [11:0] OFF_STN_ADDR_LO   = 12'h108;
    localparam logic [11:0] OFF_GRP_HASH_HI   = 12'h10C;
    localparam logic [11:0] OFF_GRP_HASH_LO   = 12'h110;
    localparam logic [11:0] OFF_PHY_MGMT_ACC  = 12'h114;
    localparam logic [11:0] OFF_PHY_MGMT_DAT  = 12'h118;
    localparam logic [11:0] OFF_PAUSE_CTRL    = 12'h11C;
    localparam logic [11:0] OFF_VLAN_ONE      = 12'h120;
    localparam logic [11:0] OFF_VLAN_TWO      = 12'h124;
    localparam logic [11:0] OFF_WAKE_FILT     = 12'h128;
    localparam logic [11:0] OFF_WAKE_CSR      = 12'h12C;
    localparam logic [11:0] OFF_CSUM_CTRL     = 12'h130;
    localparam logic [11:0] OFF_RSV_FIRST     = 12'h134;
    localparam logic [11:0] OFF_RSV_LAST      = 12'h1FC;
    localparam logic [11:0] OFF_MODE_STATUS   = 12'h200;
    localparam int          NUM_REGS          = 13;
    localparam int          IDX_W             = 4;

    // ************************************************************
    // mode control fields
    // ************************************************************
    localparam int BIT_ACCEPT_ALL   = 31;
    localparam int BIT_OWN_SUPPRESS = 23;
    localparam int BIT_LOOP_SELECT  = 21;
    localparam int BIT_DUPLEX_FULL  = 20;
    localparam int BIT_GROUP_PASS   = 19;
    localparam int BIT_ANY_DEST     = 18;
    localparam int BIT_FILT_INVERT  = 17;
    localparam int BIT_ERR_DELIVER  = 16;
    localparam int BIT_HASH_ONLY    = 15;
    localparam int BIT_HASH_SELECT  = 13;
    localparam logic [31:0] MODE_RESET = 32'h0004_0000;
    localparam logic [31:0] MODE_WMASK = 32'h80BF_A000;

    // ************************************************************
    // status fields
    // ************************************************************
    localparam int BIT_ST_LOOP_ACTIVE = 0;
    localparam int BIT_ST_SETTLING    = 1;
    localparam int BIT_ST_FILT_FAIL   = 2;

    // ************************************************************
    // station address, hash and mii widths
    // ************************************************************
    localparam int STN_HI_W  = 16;
    localparam int ADDR_W    = 48;
    localparam int HASH_W    = 64;
    localparam int HASH_IDX_W = 6;
    localparam int MII_W     = 4;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int CLK_PERIOD_NS   = 4;
    localparam int LOOP_SETTLE_NS  = 10000;
    localparam int LOOP_SETTLE_CYC = LOOP_SETTLE_NS / CLK_PERIOD_NS;
    localparam int CNT_W           = 12;

endpackage : mmc_pkg

// ===== rtl/mmc_cfg_if.sv
interface mmc_cfg_if;
    import mmc_pkg::*;

    logic                  accept_every_frame;
    logic                  own_frame_suppress;
    logic                  internal_loop_select;
    logic                  duplex_full_select;
    logic                  group_frames_pass;
    logic                  accept_any_destination;
    logic                  filter_invert;
    logic                  deliver_errored_frames;
    logic                  hash_or_exact_filter_select;
    logic                  hash_only;
    logic [ADDR_W-1:0]     station_addr;
    logic [HASH_W-1:0]     group_hash;
    logic                  loop_active;
    logic                  settling;
    logic                  filt_fail;

    modport regs (
        output accept_every_frame, own_frame_suppress, internal_loop_select,
               duplex_full_select, group_frames_pass, accept_any_destination,
               filter_invert, deliver_errored_frames,
               hash_or_exact_filter_select, hash_only, station_addr,
               group_hash,
        input  loop_active, settling, filt_fail
    );
    modport filt (
        input  accept_every_frame, group_frames_pass, accept_any_destination,
               filter_invert, deliver_errored_frames,
               hash_or_exact_filter_select, hash_only, station_addr,
               group_hash,
        output filt_fail
    );
    modport mux (
        input  own_frame_suppress, internal_loop_select, duplex_full_select,
        output loop_active, settling
    );
endinterface : mmc_cfg_if

// ===== rtl/mmc_addr_filter.sv
module mmc_addr_filter
    import mmc_pkg::*;
(
    // clock and reset
    input  wire logic                  i_clock,
    input  wire logic                  i_nrst,
    // configuration
    mmc_cfg_if.filt                    cfg,
    // frame events
    input  wire logic                  i_dest_valid,
    input  wire logic [ADDR_W-1:0]     i_dest,
    input  wire logic [HASH_IDX_W-1:0] i_hash_idx,
    input  wire logic                  i_end,
    input  wire logic                  i_err_runt,
    input  wire logic                  i_err_coll,
    input  wire logic                  i_err_trunc,
    // decision
    output logic                       o_deliver,
    output logic                       o_status_valid,
    output logic                       o_filter_fail
);

    logic pass_q, pass_d;
    logic deliver_q, deliver_d;
    logic stat_q, stat_d;
    logic fail_q, fail_d;
    logic is_group, exact_hit, hash_hit, addr_ok, bad;

    // ************************************************************
    // address check
    // ************************************************************
    always_comb begin
        is_group  = i_dest[0];
        exact_hit = (i_dest == cfg.station_addr);
        hash_hit  = cfg.group_hash[i_hash_idx];
        if (cfg.hash_or_exact_filter_select) begin
            if (is_group || cfg.hash_only) begin
                addr_ok = hash_hit;
            end else begin
                addr_ok = exact_hit;
            end
        end else begin
            addr_ok = exact_hit ^ cfg.filter_invert;
        end
        if (cfg.group_frames_pass && is_group) begin
            addr_ok = 1'b1;
        end
        if (cfg.accept_any_destination) begin
            addr_ok = 1'b1;
        end
    end

    // ************************************************************
    // frame decision
    // ************************************************************
    always_comb begin
        bad       = i_err_runt | i_err_coll | i_err_trunc;
        pass_d    = i_dest_valid ? addr_ok : pass_q;
        deliver_d = 1'b0;
        stat_d    = i_end;
        fail_d    = i_end ? ~pass_q : fail_q;
        if (i_end) begin
            if (cfg.accept_every_frame) begin
                deliver_d = 1'b1;
            end else begin
                deliver_d = pass_q & (~bad | cfg.deliver_errored_frames);
            end
        end
    end

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            pass_q    <= 1'b0;
            deliver_q <= 1'b0;
            stat_q    <= 1'b0;
            fail_q    <= 1'b0;
        end else begin
            pass_q    <= pass_d;
            deliver_q <= deliver_d;
            stat_q    <= stat_d;
            fail_q    <= fail_d;
        end
    end

    assign o_deliver      = deliver_q;
    assign o_status_valid = stat_q;
    assign o_filter_fail  = fail_q;
    assign cfg.filt_fail  = fail_q;

endmodule : mmc_addr_filter

// ===== rtl/mmc_loop_mux.sv
module mmc_loop_mux
    import mmc_pkg::*;
(
    // clock and reset
    input  wire logic             i_clock,
    input  wire logic             i_nrst,
    // configuration
    mmc_cfg_if.mux                cfg,
    // mac transmit side
    input  wire logic [MII_W-1:0] i_mac_txd,
    input  wire logic             i_mac_txen,
    // phy receive side
    input  wire logic [MII_W-1:0] i_phy_rxd,
    input  wire logic             i_phy_rxdv,
    // switched outputs
    output logic      [MII_W-1:0] o_phy_txd,
    output logic                  o_phy_txen,
    output logic      [MII_W-1:0] o_mac_rxd,
    output logic                  o_mac_rxdv,
    output logic                  o_tx_defer
);

    localparam logic [CNT_W-1:0] SETTLE_LOAD = CNT_W'(LOOP_SETTLE_CYC - 1);

    logic             loop_q, loop_d;
    logic             busy_q, busy_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic [MII_W-1:0] ptxd_q, ptxd_d, mrxd_q, mrxd_d;
    logic             ptxen_q, ptxen_d, mrxdv_q, mrxdv_d, defer_q, defer_d;

    // ************************************************************
    // mode change sequencing
    // ************************************************************
    always_comb begin
        loop_d = loop_q;
        busy_d = busy_q;
        cnt_d  = cnt_q;
        if (busy_q) begin
            if (cnt_q == '0) begin
                busy_d = 1'b0;
                loop_d = cfg.internal_loop_select;
            end else begin
                cnt_d = cnt_q - 1'b1;
            end
        end else if (cfg.internal_loop_select != loop_q) begin
            busy_d = 1'b1;
            cnt_d  = SETTLE_LOAD;
        end
    end

    // ************************************************************
    // datapath switch
    // ************************************************************
    always_comb begin
        ptxd_d  = '0;
        ptxen_d = 1'b0;
        mrxd_d  = '0;
        mrxdv_d = 1'b0;
        if (!busy_q) begin
            // loop returns tx, phy stays quiet
            if (loop_q) begin
                mrxd_d  = i_mac_txd;
                mrxdv_d = i_mac_txen;
            end else begin
                ptxd_d  = i_mac_txd;
                ptxen_d = i_mac_txen;
                mrxd_d  = i_phy_rxd;
                mrxdv_d = i_phy_rxdv;
            end
        end
        if (cfg.own_frame_suppress && i_mac_txen) begin
            mrxd_d  = '0;
            mrxdv_d = 1'b0;
        end
        defer_d = ~cfg.duplex_full_select & i_phy_rxdv & ~loop_q;
    end

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            loop_q  <= 1'b0;
            busy_q  <= 1'b0;
            cnt_q   <= '0;
            ptxd_q  <= '0;
            ptxen_q <= 1'b0;
            mrxd_q  <= '0;
            mrxdv_q <= 1'b0;
            defer_q <= 1'b0;
        end else begin
            loop_q  <= loop_d;
            busy_q  <= busy_d;
            cnt_q   <= cnt_d;
            ptxd_q  <= ptxd_d;
            ptxen_q <= ptxen_d;
            mrxd_q  <= mrxd_d;
            mrxdv_q <= mrxdv_d;
            defer_q <= defer_d;
        end
    end

    assign o_phy_txd       = ptxd_q;
    assign o_phy_txen      = ptxen_q;
    assign o_mac_rxd       = mrxd_q;
    assign o_mac_rxdv      = mrxdv_q;
    assign o_tx_defer      = defer_q;
    assign cfg.loop_active = loop_q;
    assign cfg.settling    = busy_q;

endmodule : mmc_loop_mux

// ===== rtl/mmc_top.sv
// How it works
// - receive-all takes every frame, reports filter result
// - own-suppress blocks reception while transmitting
// - loop bit returns tx frames internally
// - loop mode change completes 2501 cycles after the write, just over ten microseconds
// - full duplex lets tx and rx overlap
// - pass-group accepts every multicast frame
// - unicast still needs station address match
// - promiscuous accepts all, set after reset
// - inverse flips exact-match decision only
// - pass-bad delivers errored frames that passed
// - register group at 100h-130h, 134h-1FCh reserved
// - exact filtering against station address when clear
module mmc_top
    import mmc_pkg::*;
(
    // clock and reset
    input  wire logic                  i_clock,
    input  wire logic                  i_nrst,
    // ahb-lite slave
    input  wire logic                  i_hsel,
    input  wire logic [31:0]           i_haddr,
    input  wire logic [1:0]            i_htrans,
    input  wire logic                  i_hwrite,
    input  wire logic [2:0]            i_hsize,
    input  wire logic [31:0]           i_hwdata,
    input  wire logic                  i_hready,
    output logic      [31:0]           o_hrdata,
    output logic                       o_hreadyout,
    output logic                       o_hresp,
    // mac transmit side
    input  wire logic [MII_W-1:0]      i_mac_txd,
    input  wire logic                  i_mac_txen,
    // phy receive side
    input  wire logic [MII_W-1:0]      i_phy_rxd,
    input  wire logic                  i_phy_rxdv,
    // switched mii
    output logic      [MII_W-1:0]      o_phy_txd,
    output logic                       o_phy_txen,
    output logic      [MII_W-1:0]      o_mac_rxd,
    output logic                       o_mac_rxdv,
    output logic                       o_tx_defer,
    // receive frame events
    input  wire logic                  i_rx_dest_valid,
    input  wire logic [ADDR_W-1:0]     i_rx_dest,
    input  wire logic [HASH_IDX_W-1:0] i_rx_hash_idx,
    input  wire logic                  i_rx_end,
    input  wire logic                  i_rx_err_runt,
    input  wire logic                  i_rx_err_coll,
    input  wire logic                  i_rx_err_trunc,
    // receive decision
    output logic                       o_rx_deliver,
    output logic                       o_rx_status_valid,
    output logic                       o_rx_filter_fail
);

    // ************************************************************
    // decode helpers
    // ************************************************************
    function automatic logic group_hit(input logic [31:0] a);
        group_hit = (a[31:12] == '0) && (a[11:0] >= OFF_MODE_CTRL) &&
                    (a[11:0] <= OFF_CSUM_CTRL);
    endfunction : group_hit

    function automatic logic [IDX_W-1:0] reg_index(input logic [31:0] a);
        logic [11:0] rel;
        rel       = a[11:0] - OFF_MODE_CTRL;
        reg_index = rel[IDX_W+1:2];
    endfunction : reg_index

    function automatic logic status_hit(input logic [31:0] a);
        status_hit = (a[31:12] == '0) && (a[11:0] == OFF_MODE_STATUS);
    endfunction : status_hit

    // ************************************************************
    // state
    // ************************************************************
    mmc_cfg_if cfg_bus ();

    logic [31:0]      regs_q [NUM_REGS];
    logic [31:0]      regs_d [NUM_REGS];
    logic             wr_pend_q, wr_pend_d;
    logic [31:0]      wr_addr_q, wr_addr_d;
    logic [31:0]      rdata_q, rdata_d;
    logic             addr_phase;
    logic [31:0]      status_word;

    // ************************************************************
    // bus slave next state
    // ************************************************************
    always_comb begin
        addr_phase = i_hsel & i_htrans[1] & i_hready;
        for (int i = 0; i < NUM_REGS; i++) begin
            regs_d[i] = regs_q[i];
        end
        if (wr_pend_q && group_hit(wr_addr_q)) begin
            if (reg_index(wr_addr_q) == '0) begin
                regs_d[0] = i_hwdata & MODE_WMASK;
            end else begin
                regs_d[reg_index(wr_addr_q)] = i_hwdata;
            end
        end
        wr_pend_d = addr_phase & i_hwrite;
        wr_addr_d = addr_phase ? i_haddr : wr_addr_q;
        rdata_d   = rdata_q;
        if (addr_phase) begin
            rdata_d = '0;
            if (!i_hwrite) begin
                if (group_hit(i_haddr)) begin
                    rdata_d = regs_d[reg_index(i_haddr)];
                end else if (status_hit(i_haddr)) begin
                    rdata_d = status_word;
                end
            end
        end
    end

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                regs_q[i] <= '0;
            end
            regs_q[0] <= MODE_RESET;
            wr_pend_q <= 1'b0;
            wr_addr_q <= '0;
            rdata_q   <= '0;
        end else begin
            for (int i = 0; i < NUM_REGS; i++) begin
                regs_q[i] <= regs_d[i];
            end
            wr_pend_q <= wr_pend_d;
            wr_addr_q <= wr_addr_d;
            rdata_q   <= rdata_d;
        end
    end

    assign o_hrdata    = rdata_q;
    assign o_hreadyout = 1'b1;
    assign o_hresp     = 1'b0;

    // ************************************************************
    // configuration fan-out
    // ************************************************************
    assign cfg_bus.accept_every_frame          = regs_q[0][BIT_ACCEPT_ALL];
    assign cfg_bus.own_frame_suppress          = regs_q[0][BIT_OWN_SUPPRESS];
    assign cfg_bus.internal_loop_select        = regs_q[0][BIT_LOOP_SELECT];
    assign cfg_bus.duplex_full_select          = regs_q[0][BIT_DUPLEX_FULL];
    assign cfg_bus.group_frames_pass           = regs_q[0][BIT_GROUP_PASS];
    assign cfg_bus.accept_any_destination      = regs_q[0][BIT_ANY_DEST];
    assign cfg_bus.filter_invert               = regs_q[0][BIT_FILT_INVERT];
    assign cfg_bus.deliver_errored_frames      = regs_q[0][BIT_ERR_DELIVER];
    assign cfg_bus.hash_or_exact_filter_select = regs_q[0][BIT_HASH_SELECT];
    assign cfg_bus.hash_only                   = regs_q[0][BIT_HASH_ONLY];
    assign cfg_bus.station_addr = {regs_q[1][STN_HI_W-1:0], regs_q[2]};
    assign cfg_bus.group_hash   = {regs_q[3], regs_q[4]};

    always_comb begin
        status_word                     = '0;
        status_word[BIT_ST_LOOP_ACTIVE] = cfg_bus.loop_active;
        status_word[BIT_ST_SETTLING]    = cfg_bus.settling;
        status_word[BIT_ST_FILT_FAIL]   = cfg_bus.filt_fail;
    end

    // ************************************************************
    // submodules
    // ************************************************************
    mmc_addr_filter u_filter (
        .i_clock        (i_clock),
        .i_nrst         (i_nrst),
        .cfg            (cfg_bus.filt),
        .i_dest_valid   (i_rx_dest_valid),
        .i_dest         (i_rx_dest),
        .i_hash_idx     (i_rx_hash_idx),
        .i_end          (i_rx_end),
        .i_err_runt     (i_rx_err_runt),
        .i_err_coll     (i_rx_err_coll),
        .i_err_trunc    (i_rx_err_trunc),
        .o_deliver      (o_rx_deliver),
        .o_status_valid (o_rx_status_valid),
        .o_filter_fail  (o_rx_filter_fail)
    );

    mmc_loop_mux u_mux (
        .i_clock    (i_clock),
        .i_nrst     (i_nrst),
        .cfg        (cfg_bus.mux),
        .i_mac_txd  (i_mac_txd),
        .i_mac_txen (i_mac_txen),
        .i_phy_rxd  (i_phy_rxd),
        .i_phy_rxdv (i_phy_rxdv),
        .o_phy_txd  (o_phy_txd),
        .o_phy_txen (o_phy_txen),
        .o_mac_rxd  (o_mac_rxd),
        .o_mac_rxdv (o_mac_rxdv),
        .o_tx_defer (o_tx_defer)
    );

endmodule : mmc_top

// ===== tb/mmc_top_properties.sv
module mmc_top_props
    import mmc_pkg::*;
(
    // bus and mii data nibbles
    input wire logic        i_clock, i_nrst, i_hsel, i_hwrite, i_hready,
    input wire logic [1:0]  i_htrans,
    input wire logic [31:0] i_haddr, i_hwdata, o_hrdata,
    input wire logic        o_hresp,
    input wire logic [3:0]  i_mac_txd, o_phy_txd, o_mac_rxd,
    // mii and frames
    input wire logic        i_mac_txen, o_phy_txen, o_mac_rxdv, o_tx_defer,
    input wire logic        i_rx_end, i_rx_err_runt, i_rx_err_coll,
    input wire logic        i_rx_err_trunc, o_rx_deliver, o_rx_status_valid,
    input wire logic        o_rx_filter_fail
);
    timeunit 1ns / 1ps;
    logic        wr_q;
    logic        rd_q;
    logic [31:0] mode_q;
    logic [11:0] cnt_q;
    wire logic   take = i_hsel && i_htrans[1] && i_hready
                        && i_haddr == {20'h0, OFF_MODE_CTRL};
    wire logic   err_any = i_rx_err_runt | i_rx_err_coll | i_rx_err_trunc;

    // shadow mode word, cycles since loop change
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            wr_q   <= 1'b0;
            rd_q   <= 1'b0;
            mode_q <= MODE_RESET;
            cnt_q  <= '1;
        end else begin
            wr_q <= take && i_hwrite;
            rd_q <= take && !i_hwrite;
            if (wr_q) begin
                mode_q <= i_hwdata & MODE_WMASK;
            end
            if (wr_q && i_hwdata[21] != mode_q[21]) begin
                cnt_q <= '0;
            end else if (cnt_q != '1) begin
                cnt_q <= cnt_q + 1'b1;
            end
        end
    end

    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_nrst);

    a_mode_readback: assert property (rd_q |-> o_hrdata == mode_q)
        else $error("readback");
    a_bus_okay: assert property (o_hresp == 1'b0)
        else $error("hresp");
    a_status_pulse: assert property (i_rx_end |=> o_rx_status_valid)
        else $error("status");
    a_take_all: assert property (i_rx_end && mode_q[31] |=> o_rx_deliver)
        else $error("accept_every_frame");
    a_promisc_pass: assert property (i_rx_end && mode_q[18] && !err_any
        |=> o_rx_deliver && !o_rx_filter_fail) else $error("promisc");
    a_bad_gated: assert property (o_rx_deliver && !mode_q[31]
        && !mode_q[16] |-> $past(i_rx_end) && !$past(err_any))
        else $error("bad frame");
    a_own_block: assert property (mode_q[23] && i_mac_txen |=> !o_mac_rxdv)
        else $error("own rx");
    a_duplex_free: assert property (mode_q[20] |=> !o_tx_defer)
        else $error("defer");
    a_normal_tx: assert property (!mode_q[21] && cnt_q > 12'h9C6
        |=> o_phy_txen == $past(i_mac_txen)
        && o_phy_txd == $past(i_mac_txd)) else $error("tx path");
    a_loop_back: assert property (mode_q[21] && !mode_q[23]
        && cnt_q > 12'h9C6 && i_mac_txen
        |=> o_mac_rxdv && !o_phy_txen && o_mac_rxd == $past(i_mac_txd))
        else $error("loop path");
    c_loop: cover property (mode_q[21] && cnt_q == 12'h9C7);
    c_bad: cover property (o_rx_deliver && mode_q[16]);
    c_fail: cover property (o_rx_status_valid && o_rx_filter_fail);
endmodule : mmc_top_props

bind mmc_top mmc_top_props mmc_top_props_i (.*);

// ===== tb/mmc_phy_model.sv
module mmc_phy_model (
    input  wire logic       i_clock,
    input  wire logic [3:0] i_txd,
    input  wire logic       i_txen,
    output logic      [3:0] o_rxd,
    output logic            o_rxdv
);
    timeunit 1ns / 1ps;
    int         n_tx = 0;
    logic [3:0] nib = 4'hA;
    initial begin
        o_rxd = 4'h5;
        o_rxdv = 1'b0;
    end
    always @(posedge i_clock) begin
        if (i_txen === 1'b1) n_tx++;
    end
    // idle line shows inverted last nibble
    task automatic send(input int n);
        repeat (n) begin
            @(posedge i_clock);
            nib = nib + 4'h3;
            o_rxd <= nib;
            o_rxdv <= 1'b1;
        end
        @(posedge i_clock);
        o_rxd <= ~nib;
        o_rxdv <= 1'b0;
    endtask : send
endmodule : mmc_phy_model

// ===== tb/tb.sv
module tb
    import mmc_pkg::*;
;
    timeunit 1ns / 1ps;
    logic i_clock, i_nrst = '0, i_hsel = '0, i_hwrite = '0;
    logic i_mac_txen = '0, i_rx_dest_valid = '0, i_rx_end = '0;
    logic rd_dp = '0, i_phy_rxdv, o_hreadyout, o_hresp, o_phy_txen;
    logic o_mac_rxdv, o_tx_defer, o_rx_deliver, o_rx_status_valid;
    logic o_rx_filter_fail;
    logic [31:0] i_haddr = '0, i_hwdata = '0, o_hrdata;
    logic [31:0] rnd = 32'h1570F;
    logic [1:0] i_htrans = '0;
    logic [2:0] errs = '0;
    logic [3:0] i_mac_txd = '0, i_phy_rxd, o_phy_txd, o_mac_rxd;
    logic [47:0] i_rx_dest = '0, stn;
    logic [5:0] i_rx_hash_idx = '0;
    logic [31:0] rq[$];
    logic [1:0] fq[$];
    int fails = 0, n_tests = 0, n_rxdv = 0, n_defer = 0;

    mmc_top mmc_top_i (.i_hsize(3'h2), .i_hready(o_hreadyout),
        .i_rx_err_runt(errs[0]), .i_rx_err_coll(errs[1]),
        .i_rx_err_trunc(errs[2]), .*);
    mmc_phy_model mmc_phy_model_i (.i_clock, .i_txd(o_phy_txd),
        .i_txen(o_phy_txen), .o_rxd(i_phy_rxd), .o_rxdv(i_phy_rxdv));

    initial begin
        i_clock = 1'b0;
        forever #2 i_clock = ~i_clock;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic check(input logic [31:0] seen, exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %0t got %h want %h", $time, seen, exp);
        end
    endtask : check
    task automatic tally_and_finish;
        if (fails == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : tally_and_finish
    // ****************************************
    // drivers
    // ****************************************
    task automatic wr(input logic [11:0] a, input logic w,
                      input logic [31:0] d);
        @(posedge i_clock);
        i_hsel <= 1'b1;
        i_htrans <= 2'h2;
        i_haddr <= {20'h0, a};
        i_hwrite <= w;
        do @(posedge i_clock); while (o_hreadyout !== 1'b1);
        i_htrans <= '0;
        i_hsel <= 1'b0;
        i_hwdata <= d;
        rd_dp <= !w;
        do @(posedge i_clock); while (o_hreadyout !== 1'b1);
        rd_dp <= 1'b0;
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        rq.push_back(e);
        wr(a, 1'b0, '0);
    endtask : rd
    task automatic md(input logic [31:0] m);
        wr(OFF_MODE_CTRL, 1'b1, m);
    endtask : md
    task automatic frm(input logic [1:0] k, exp, input logic [2:0] e = '0);
        rnd = lfsr(rnd);
        fq.push_back(exp);
        @(posedge i_clock);
        i_rx_dest_valid <= 1'b1;
        i_rx_hash_idx <= rnd[5:0];
        i_rx_dest <= stn ^ {k[0], 14'h0, rnd & {32{k != 2'h0}}, k[1]};
        @(posedge i_clock);
        i_rx_dest_valid <= 1'b0;
        i_rx_end <= 1'b1;
        errs <= e;
        @(posedge i_clock);
        i_rx_end <= 1'b0;
        errs <= '0;
    endtask : frm
    task automatic tx(input logic [31:0] m, input logic rx);
        md(m);
        n_rxdv = 0;
        n_defer = 0;
        mmc_phy_model_i.n_tx = 0;
        if (rx) fork mmc_phy_model_i.send(8); join_none
        repeat (8) begin
            @(posedge i_clock);
            rnd = lfsr(rnd);
            i_mac_txen <= 1'b1;
            i_mac_txd <= rnd[3:0];
        end
        @(posedge i_clock);
        i_mac_txen <= 1'b0;
        repeat (4) @(posedge i_clock);
    endtask : tx
    // ****************************************
    // monitor and sequence
    // ****************************************
    always @(posedge i_clock) begin
        if (rd_dp === 1'b1) check(o_hrdata, rq.pop_front());
        if (o_rx_status_valid === 1'b1)
            check({o_rx_deliver, o_rx_filter_fail}, fq.pop_front());
        if (o_mac_rxdv === 1'b1) n_rxdv++;
        if (o_tx_defer === 1'b1) n_defer++;
    end
    initial begin
        repeat (20000) @(posedge i_clock);
        fails++;
        tally_and_finish();
    end
    initial begin
        repeat (6) @(posedge i_clock);
        i_nrst <= 1'b1;
        rd(OFF_MODE_CTRL, MODE_RESET);
        md(32'hFFDF_FFFF);
        rd(OFF_MODE_CTRL, MODE_WMASK & 32'hFFDF_FFFF);
        for (logic [11:0] a = 12'h108; a <= 12'h130; a += 12'h004) begin
            rnd = lfsr(rnd);
            wr(a, 1'b1, rnd);
            rd(a, rnd);
        end
        wr(OFF_RSV_FIRST, 1'b1, 32'hFFFF_FFFF);
        rd(OFF_RSV_FIRST, '0);
        rd(OFF_RSV_LAST, '0);
        stn = {1'b0, rnd[14:0], rnd[31:1], 1'b0};
        wr(OFF_STN_ADDR_HI, 1'b1, {16'h0, stn[47:32]});
        wr(OFF_STN_ADDR_LO, 1'b1, stn[31:0]);
        md(MODE_RESET);
        frm(2'h1, 2'h2);
        md('0);
        frm(2'h0, 2'h2);
        frm(2'h1, 2'h1);
        md(32'h0002_0000);
        frm(2'h0, 2'h1);
        frm(2'h1, 2'h2);
        md(32'h0008_0000);
        frm(2'h2, 2'h2);
        frm(2'h1, 2'h1);
        frm(2'h0, 2'h2);
        md(32'h8000_0000);
        frm(2'h1, 2'h3, 3'h4);
        for (logic [2:0] e = 3'h1; e != 3'h0; e <<= 1) begin
            md('0);
            frm(2'h0, 2'h0, e);
            md(32'h0001_0000);
            frm(2'h0, 2'h2, e);
            frm(2'h1, 2'h1, e);
        end
        tx(32'h0080_0000, 1'b1);
        check(n_rxdv, 0);
        check(n_defer, 8);
        tx('0, 1'b1);
        check(n_rxdv, 8);
        tx(32'h0010_0000, 1'b1);
        check(n_rxdv, 8);
        check(n_defer, 0);
        md(32'h0030_0000);
        repeat (2503) @(posedge i_clock);
        rd(OFF_MODE_STATUS, 32'h5);
        tx(32'h0030_0000, 1'b0);
        check(mmc_phy_model_i.n_tx, 0);
        check(n_rxdv, 8);
        md(32'h0010_0000);
        repeat (2503) @(posedge i_clock);
        tx(32'h0010_0000, 1'b0);
        check(mmc_phy_model_i.n_tx, 8);
        tally_and_finish();
    end
endmodule : tb
